// [logic/mod_burst_ctrl.sv]
// How it works
// - BPSK shift -360..+360 degrees, reset 180
// - Sources internal/external/channels; keying refuses channels
// - External AM depth follows input
// - External FM deviation scales with input
// - External PM deviation scales with input
// - External PWM width deviation scales with input
// - Ext keying: low carrier, high shifted
// - Keying input ignores edge select setting
// - Internal keying alternates at configured rate
// - Channel modulating itself is refused
// - Enables reset off, at most one
// - Modulation enable clears sweep and burst
// - PWM only with pulse waveform
// - Burst waveform and frequency limits enforced
// - Count 1..100,000,000 or infinite, triggered only
// - Each burst restarts the bit sequence
// - Period 1 us..8000 s, timer trigger only
// - Start phase -360..+360, both modes
// - Trigger outputs count cycles then waits
// - Gate false finishes cycle then holds
// - Two burst modes; each ignores the other's settings
// - Gate polarity selectable, normal after reset
// - Noise stops at once on gate false
// - Internal keying is 50% square wave
`include "mod_burst_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module mod_burst_ctrl (
    // Clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      reset,
    // Register port
    input  wire logic [7:0]                addr,
    input  wire logic [31:0]               wdata,
    input  wire logic                      wr_stb,
    input  wire logic                      rd_stb,
    output logic [31:0]                    rdata,
    // Trigger pin and waveform engine
    input  wire logic                      trig_in,
    input  wire logic                      manual_trigger,
    input  wire logic                      cycle_end,
    input  wire logic signed [11:0]        mod_in,
    // Control outputs
    output mod_burst_pkg::mod_ctrl_t       mod_ctrl,
    output logic                           sweep_on,
    output logic                           key_shift,
    output logic signed [9:0]              bpsk_phase,
    output logic signed [15:0]             mod_term,
    output logic                           output_on,
    output logic                           burst_restart,
    output logic signed [9:0]              start_phase
);

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    mod_burst_pkg::wave_func_t   func;
    mod_burst_pkg::burst_state_t state;
    mod_burst_pkg::burst_state_t next_state;
    logic        own_ch;
    logic        below_min;
    logic        above_6m;
    logic [31:0] phase_rate;
    logic [31:0] freq_rate;
    logic        burst_en;
    logic        gated;
    logic        gate_active_low;
    logic [1:0]  trig_src;
    logic        trigger_edge_select;
    logic        count_inf;
    logic [26:0] burst_cycle_count;
    logic [32:0] period;
    logic signed [15:0] deviation;
    logic        err;

    // ----------------------------------------
    // Write decode and legality checks
    // ----------------------------------------
    wire wr_mod   = wr_stb && addr == `OFS_MOD_CTRL;
    wire wr_wave  = wr_stb && addr == `OFS_WAVE_CTRL;
    wire wr_bph   = wr_stb && addr == `OFS_BPSK_PHASE;
    wire wr_burst = wr_stb && addr == `OFS_BURST_CTRL;
    wire wr_cnt   = wr_stb && addr == `OFS_BURST_COUNT;
    wire wr_plo   = wr_stb && addr == `OFS_PERIOD_LO;
    wire wr_phi   = wr_stb && addr == `OFS_PERIOD_HI;
    wire wr_sph   = wr_stb && addr == `OFS_BURST_PHASE;
    wire wr_cmd   = wr_stb && addr == `OFS_COMMAND;

    wire [5:0]       w_en   = wdata[5:0];
    wire [1:0]       w_src  = wdata[9:8];
    wire signed [9:0] w_ang = wdata[9:0];
    wire ang_bad = w_ang > `PHASE_MAX || w_ang < -`PHASE_MAX
                   || wdata[31:10] != {22{wdata[9]}};
    wire is_pulse = func == mod_burst_pkg::fn_pulse;
    wire sine_sq  = func == mod_burst_pkg::fn_sine
                    || func == mod_burst_pkg::fn_square;

    // At most one type, keying never from a channel, no self source
    wire mod_bad = $countones(w_en) > 1
                   || (w_src[1] && |w_en[`BIT_FSK:`BIT_BPSK])
                   || w_src == {1'b1, own_ch}
                   || (w_en[`BIT_PWM] && !is_pulse);
    wire wave_bad = mod_ctrl.src == {1'b1, wdata[8]}
                    || (mod_ctrl.en[`BIT_PWM]
                        && wdata[2:0] != 3'h3);

    // Burst legality against waveform, trigger source and count
    wire b_gate = wdata[1];
    wire burst_bad = wdata[0] && (func == mod_burst_pkg::fn_dc
        || (func == mod_burst_pkg::fn_noise && !b_gate)
        || (!b_gate && wdata[5:4] == 2'h0 && below_min)
        || (!b_gate && sine_sq && above_6m && !count_inf));
    wire w_inf = wdata[`BIT_COUNT_INF];
    wire cnt_bad = (!w_inf && (wdata[26:0] == 27'h0
                    || wdata[26:0] > `COUNT_MAX
                    || wdata[30:27] != 4'h0))
                   || (burst_en && !gated && sine_sq && above_6m
                       && !w_inf);
    wire [32:0] w_plo = {period[32], wdata};
    wire [32:0] w_phi = {wdata[0], period[31:0]};
    wire plo_bad = w_plo == 33'h0 || w_plo > `PERIOD_MAX_US;
    wire phi_bad = w_phi == 33'h0 || w_phi > `PERIOD_MAX_US
                   || wdata[31:1] != 31'h0;

    wire refused = (wr_mod && mod_bad) || (wr_wave && wave_bad)
                   || ((wr_bph || wr_sph) && ang_bad)
                   || (wr_burst && burst_bad) || (wr_cnt && cnt_bad)
                   || (wr_plo && plo_bad) || (wr_phi && phi_bad);
    wire mod_on_wr   = wr_mod && !mod_bad && |w_en;
    wire burst_on_wr = wr_burst && !burst_bad && wdata[0];
    wire burst_clr   = mod_on_wr || (wr_wave && !wave_bad && wdata[4]);

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mod_ctrl <= '{6'h00, mod_burst_pkg::src_internal};
            func      <= mod_burst_pkg::fn_sine;
            sweep_on  <= 1'b0;
            own_ch    <= 1'b0;
            below_min <= 1'b0;
            above_6m  <= 1'b0;
            bpsk_phase  <= `BPSK_PHASE_RST;
            phase_rate  <= `KEY_HALF_RST;
            freq_rate   <= `KEY_HALF_RST;
            burst_en    <= 1'b0;
            gated       <= 1'b0;
            gate_active_low     <= 1'b0;
            trig_src            <= 2'h0;
            trigger_edge_select <= 1'b0;
            count_inf   <= 1'b0;
            burst_cycle_count <= 27'h1;
            period      <= `PERIOD_RST_US;
            start_phase <= 10'sh000;
            deviation   <= 16'sh0000;
        end else begin
            // Refused writes fall through and keep the old value
            if (wr_mod && !mod_bad) begin
                mod_ctrl.en  <= w_en;
                mod_ctrl.src <= mod_burst_pkg::mod_src_t'(w_src);
            end else if (burst_on_wr || (wr_wave && !wave_bad
                                         && wdata[4])) begin
                mod_ctrl.en <= 6'h00;
            end
            if (wr_wave && !wave_bad) begin
                func      <= mod_burst_pkg::wave_func_t'(wdata[2:0]);
                own_ch    <= wdata[8];
                below_min <= wdata[12];
                above_6m  <= wdata[13];
            end
            if (mod_on_wr || burst_on_wr)
                sweep_on <= 1'b0;
            else if (wr_wave && !wave_bad)
                sweep_on <= wdata[4];
            if (wr_bph && !ang_bad)
                bpsk_phase <= w_ang;
            if (wr_stb && addr == `OFS_PHASE_RATE && wdata != 32'h0)
                phase_rate <= wdata;
            if (wr_stb && addr == `OFS_FREQ_RATE && wdata != 32'h0)
                freq_rate <= wdata;
            if (burst_clr)
                burst_en <= 1'b0;
            else if (wr_burst && !burst_bad)
                burst_en <= wdata[0];
            if (wr_burst && !burst_bad) begin
                gated               <= wdata[1];
                gate_active_low     <= wdata[2];
                trig_src            <= wdata[5:4];
                trigger_edge_select <= wdata[6];
            end
            if (wr_cnt && !cnt_bad) begin
                count_inf         <= w_inf;
                burst_cycle_count <= wdata[26:0];
            end
            if (wr_plo && !plo_bad)
                period <= w_plo;
            else if (wr_phi && !phi_bad)
                period <= w_phi;
            if (wr_sph && !ang_bad)
                start_phase <= w_ang;
            if (wr_stb && addr == `OFS_DEVIATION)
                deviation <= wdata[15:0];
        end
    end

    // ----------------------------------------
    // Trigger pin synchroniser
    // ----------------------------------------
    logic [2:0] trig_sync;
    logic       trig_lvl;
    logic       trig_lvl_d;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            trig_sync  <= 3'h0;
            trig_lvl   <= 1'b0;
            trig_lvl_d <= 1'b0;
        end else begin
            trig_sync <= {trig_sync[1:0], trig_in};
            if (trig_sync[1] == trig_sync[2])
                trig_lvl <= trig_sync[2];
            trig_lvl_d <= trig_lvl;
        end
    end

    // ----------------------------------------
    // Phase and frequency keying
    // ----------------------------------------
    wire keying = |mod_ctrl.en[`BIT_FSK:`BIT_BPSK];
    wire [31:0] half = mod_ctrl.en[`BIT_BPSK] ? phase_rate : freq_rate;
    wire ext_src = mod_ctrl.src == mod_burst_pkg::src_external;
    logic [31:0] key_cnt;
    logic        int_key;

    always_ff @(posedge ref_clk) begin
        if (reset || !keying || ext_src) begin
            key_cnt <= 32'h0;
            int_key <= 1'b0;
        end else if (key_cnt >= half - 32'h1) begin
            key_cnt <= 32'h0;
            int_key <= !int_key;
        end else begin
            key_cnt <= key_cnt + 32'h1;
        end
    end

    // Level keyed at fixed polarity; the edge select is not consulted
    wire next_key = keying && (ext_src ? trig_lvl : int_key);

    // ----------------------------------------
    // External analog modulation scaling
    // ----------------------------------------
    // Full scale input code maps to full set deviation or depth
    wire signed [27:0] prod = deviation * mod_in;
    wire ext_analog = ext_src && |mod_ctrl.en[`BIT_PWM:`BIT_AM];

    // ----------------------------------------
    // Burst trigger sources
    // ----------------------------------------
    logic [4:0]  us_cnt;
    logic [32:0] per_cnt;
    logic        timer_tick;
    wire timer_on = burst_en && !gated && trig_src == 2'h0;
    wire us_tick  = us_cnt == 5'(`US_CYCLES - 1);

    always_ff @(posedge ref_clk) begin
        if (reset || !timer_on) begin
            us_cnt     <= 5'h00;
            per_cnt    <= 33'h0;
            timer_tick <= 1'b0;
        end else begin
            us_cnt     <= us_tick ? 5'h00 : us_cnt + 5'h01;
            timer_tick <= us_tick && per_cnt == period - 33'h1;
            if (us_tick)
                per_cnt <= per_cnt == period - 33'h1 ? 33'h0
                                                     : per_cnt + 33'h1;
        end
    end

    wire ext_edge = trigger_edge_select ? (trig_lvl_d && !trig_lvl)
                                        : (!trig_lvl_d && trig_lvl);
    wire bus_trig = wr_cmd && wdata[0];
    wire trig_evt = trig_src == 2'h0 ? timer_tick
                  : trig_src == 2'h1 ? (ext_edge || manual_trigger)
                  : trig_src == 2'h2 ? (bus_trig || manual_trigger)
                  : 1'b0;
    wire gate_true = trig_lvl ^ gate_active_low;
    wire is_noise  = func == mod_burst_pkg::fn_noise;

    // ----------------------------------------
    // Burst sequencer
    // ----------------------------------------
    logic [26:0] left;
    logic [26:0] next_left;

    always_comb begin
        next_state = state;
        next_left  = left;
        unique case (state)
            mod_burst_pkg::st_idle: begin
                if (gated ? gate_true : trig_evt) begin
                    next_state = mod_burst_pkg::st_run;
                    next_left  = burst_cycle_count;
                end
            end
            mod_burst_pkg::st_run: begin
                if (gated) begin
                    if (!gate_true)
                        next_state = is_noise
                                   ? mod_burst_pkg::st_idle
                                   : mod_burst_pkg::st_stop;
                end else if (cycle_end && !count_inf) begin
                    if (left == 27'h1)
                        next_state = mod_burst_pkg::st_idle;
                    else
                        next_left = left - 27'h1;
                end
            end
            mod_burst_pkg::st_stop: begin
                if (cycle_end)
                    next_state = mod_burst_pkg::st_idle;
            end
            default: next_state = mod_burst_pkg::st_idle;
        endcase
        if (!burst_en)
            next_state = mod_burst_pkg::st_idle;
    end

    // ----------------------------------------
    // Outputs, status and readback
    // ----------------------------------------
    wire idle_n = next_state != mod_burst_pkg::st_idle;
    wire [31:0] status = {27'h0, err, gate_true, key_shift,
                          state[2], state[1]};
    wire [31:0] rd_mux =
        addr == `OFS_MOD_CTRL    ? {22'h0, mod_ctrl.src, 2'h0,
                                    mod_ctrl.en} :
        addr == `OFS_WAVE_CTRL   ? {18'h0, above_6m, below_min, 3'h0,
                                    own_ch, 3'h0, sweep_on, 1'b0,
                                    func} :
        addr == `OFS_BPSK_PHASE  ? 32'(bpsk_phase) :
        addr == `OFS_PHASE_RATE  ? phase_rate :
        addr == `OFS_FREQ_RATE   ? freq_rate :
        addr == `OFS_BURST_CTRL  ? {25'h0, trigger_edge_select,
                                    trig_src, 1'b0, gate_active_low,
                                    gated, burst_en} :
        addr == `OFS_BURST_COUNT ? {count_inf, 4'h0,
                                    burst_cycle_count} :
        addr == `OFS_PERIOD_LO   ? period[31:0] :
        addr == `OFS_PERIOD_HI   ? {31'h0, period[32]} :
        addr == `OFS_BURST_PHASE ? 32'(start_phase) :
        addr == `OFS_DEVIATION   ? 32'(deviation) :
        addr == `OFS_STATUS      ? status : 32'h0;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state         <= mod_burst_pkg::st_idle;
            left          <= 27'h0;
            key_shift     <= 1'b0;
            mod_term      <= 16'sh0000;
            output_on     <= 1'b1;
            burst_restart <= 1'b0;
            err           <= 1'b0;
            rdata         <= 32'h0;
        end else begin
            state     <= next_state;
            left      <= next_left;
            key_shift <= next_key;
            mod_term  <= ext_analog ? prod[26:11]
                                    : 16'sh0000;
            output_on <= !burst_en || burst_clr || idle_n;
            // Phase reload and sequence restart on every burst start
            burst_restart <= state == mod_burst_pkg::st_idle
                             && idle_n;
            // A refusal in the clearing cycle still sets the flag
            err   <= refused || (err && !(wr_cmd && wdata[1]));
            rdata <= rd_stb ? rd_mux : 32'h0;
        end
    end

endmodule : mod_burst_ctrl

`default_nettype wire

// [logic/mod_burst_defines.svh]
`ifndef MOD_BURST_DEFINES_SVH
`define MOD_BURST_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_MOD_CTRL     8'h00
`define OFS_WAVE_CTRL    8'h04
`define OFS_BPSK_PHASE   8'h08
`define OFS_PHASE_RATE   8'h0C
`define OFS_FREQ_RATE    8'h10
`define OFS_BURST_CTRL   8'h14
`define OFS_BURST_COUNT  8'h18
`define OFS_PERIOD_LO    8'h1C
`define OFS_PERIOD_HI    8'h20
`define OFS_BURST_PHASE  8'h24
`define OFS_DEVIATION    8'h28
`define OFS_COMMAND      8'h2C
`define OFS_STATUS       8'h30

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_AM           0
`define BIT_PWM          3
`define BIT_BPSK         4
`define BIT_FSK          5
`define BIT_COUNT_INF    31

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define BPSK_PHASE_RST   10'sd180
`define PHASE_MAX        10'sd360
`define COUNT_MAX        27'd100000000
`define PERIOD_RST_US    33'd10000
`define PERIOD_MAX_US    33'd8000000000
`define KEY_RATE_RST_HZ  10

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ           25000000
`define CLK_NS           40
`define US_NS            1000
`define US_CYCLES        ((`US_NS + `CLK_NS - 1) / `CLK_NS)
`define KEY_HALF_RST     (`CLK_HZ / (2 * `KEY_RATE_RST_HZ))

`endif

// [logic/mod_burst_pkg.sv]
`default_nettype none
package mod_burst_pkg;

    typedef enum logic [1:0] {
        src_internal          = 2'h0,
        src_external          = 2'h1,
        first_channel_source  = 2'h2,
        second_channel_source = 2'h3
    } mod_src_t;

    typedef enum logic [2:0] {
        fn_sine = 3'h0, fn_square = 3'h1, fn_ramp = 3'h2,
        fn_pulse = 3'h3, fn_noise = 3'h4, fn_dc = 3'h5,
        pseudo_random_bit_sequence = 3'h6, fn_arb = 3'h7
    } wave_func_t;

    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_run  = 3'b010,
        st_stop = 3'b100
    } burst_state_t;

    typedef struct packed {
        logic [5:0] en;
        mod_src_t   src;
    } mod_ctrl_t;

endpackage : mod_burst_pkg
`default_nettype wire

// [verification/ext_signal_source.sv]
`timescale 1ns/10ps
`default_nettype none
module ext_signal_source (
    // Bench clock
    input  wire logic               ref_clk,
    // Levels asked for by the bench
    input  wire logic               want_level,
    input  wire logic signed [11:0] want_analog,
    // Pins toward the block
    output logic                    trig_in,
    output logic signed [11:0]      mod_in
);
    // ----------
    // Trigger pin
    // ----------
    int hold = 0;
    initial trig_in = 1'b0;
    // Edges land off the clock edge, as from an unrelated source
    always @(posedge ref_clk) begin
        if (hold > 0) begin
            hold <= hold - 1;
        end else if (want_level != trig_in) begin
            trig_in <= #7 want_level;
            hold    <= 13;
        end
    end
    assign mod_in = want_analog;
endmodule : ext_signal_source
`default_nettype wire

// [verification/mod_burst_ctrl_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module mod_burst_ctrl_properties (
    // Clock and reset
    input wire logic                     ref_clk,
    input wire logic                     reset,
    // Watched pins
    input wire logic                     trig_in,
    input wire mod_burst_pkg::mod_ctrl_t mod_ctrl,
    input wire logic                     sweep_on,
    input wire logic                     key_shift,
    input wire logic signed [9:0]        bpsk_phase,
    input wire logic signed [15:0]       mod_term,
    input wire logic                     output_on,
    input wire logic                     burst_restart,
    input wire logic signed [9:0]        start_phase
);
    // ----------
    // Checks
    // ----------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire logic key_on  = |mod_ctrl.en[5:4];
    wire logic key_ext = key_on && mod_ctrl.src == 2'h1;

    a_one_mod_on: assert property ($onehot0(mod_ctrl.en))
        else $error("more than one modulation on");
    a_mod_alone: assert property (|mod_ctrl.en |-> !sweep_on && output_on)
        else $error("modulation beside sweep or burst");
    a_key_src: assert property (key_on |-> !mod_ctrl.src[1])
        else $error("keying from a channel");
    a_bpsk_span: assert property (bpsk_phase >= -360 && bpsk_phase <= 360)
        else $error("keying phase out of span");
    a_start_span: assert property (start_phase >= -360 && start_phase <= 360)
        else $error("start phase out of span");
    a_restart_once: assert property (burst_restart |=> !burst_restart)
        else $error("restart longer than one cycle");
    a_restart_out: assert property (burst_restart |-> output_on)
        else $error("restart with output off");
    a_term_idle: assert property ((mod_ctrl.en[3:0] == 4'h0)[*2] |-> mod_term == 16'sh0)
        else $error("scaling term without analog type");
    a_key_follow: assert property ((key_ext && $stable(trig_in))[*8] |-> key_shift == trig_in)
        else $error("keying does not follow the pin");

    cover property (burst_restart);
    cover property (key_ext && key_shift);
    cover property ($fell(output_on));
endmodule : mod_burst_ctrl_properties
bind mod_burst_ctrl mod_burst_ctrl_properties chk_u (.ref_clk, .reset,
    .trig_in, .mod_ctrl, .sweep_on, .key_shift, .bpsk_phase, .mod_term,
    .output_on, .burst_restart, .start_phase);
`default_nettype wire

// [verification/modulation_burst_control_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module modulation_burst_control_tb_top;
    // ----------
    // Signals
    // ----------
    logic               ref_clk = 1'b0;
    logic               reset = 1'b1;
    logic [7:0]         addr = 8'h00;
    logic [31:0]        wdata = 32'h0;
    logic               wr_stb = 1'b0;
    logic               rd_stb = 1'b0;
    logic               manual_trigger = 1'b0;
    logic               cycle_end = 1'b0;
    logic               want_level = 1'b0;
    logic signed [11:0] want_analog = 12'sh000;
    logic signed [11:0] mod_in;
    logic [31:0]        rdata;
    logic [31:0]        rv;
    logic               trig_in;
    logic               sweep_on;
    logic               key_shift;
    logic               output_on;
    logic               burst_restart;
    logic signed [9:0]  bpsk_phase;
    logic signed [9:0]  start_phase;
    logic signed [15:0] mod_term;
    int                 fails = 0;
    int                 n_compared = 0;
    mod_burst_pkg::mod_ctrl_t mod_ctrl;

    always #20 ref_clk = ~ref_clk;
    ext_signal_source src_u (.ref_clk, .want_level, .want_analog, .trig_in,
        .mod_in);
    mod_burst_ctrl dut_u (.ref_clk, .reset, .addr, .wdata, .wr_stb, .rd_stb,
        .rdata, .trig_in, .manual_trigger, .cycle_end, .mod_in, .mod_ctrl,
        .sweep_on, .key_shift, .bpsk_phase, .mod_term, .output_on,
        .burst_restart, .start_phase);

    // ----------
    // Helpers
    // ----------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task test_done;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
        #1;
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
    endtask : rd
    task level(input logic v);
        @(posedge ref_clk);
        want_level <= v;
    endtask : level
    // Bounded wait: a hang ends the run instead of stalling it
    task wait_on(input logic want);
        int i;
        for (i = 0; i < 60 && output_on !== want; i++)
            tick(1);
        if (i == 60) begin
            fails++;
            test_done;
        end
    endtask : wait_on
    task pulse_end;
        @(posedge ref_clk);
        cycle_end <= 1'b1;
        @(posedge ref_clk);
        cycle_end <= 1'b0;
        #1;
    endtask : pulse_end

    // ----------
    // Scenarios
    // ----------
    task mod_enables;
        chk(mod_ctrl, 32'h0);
        chk(32'(bpsk_phase), 32'd180);
        rd(8'h14, rv);
        chk(rv[2], 1'b0);
        wr(8'h04, 32'h3);
        for (int i = 0; i < 6; i++) begin
            wr(8'h00, 32'h1 << i);
            chk(mod_ctrl.en, 32'h1 << i);
        end
        wr(8'h00, 32'h3);
        chk(mod_ctrl.en, 32'h20);
        wr(8'h00, 32'h210);
        chk(mod_ctrl.en, 32'h20);
        wr(8'h00, 32'h201);
        chk(mod_ctrl, 32'h80);
        rd(8'h30, rv);
        chk(rv[4], 1'b1);
        wr(8'h2C, 32'h2);
        wr(8'h00, 32'h301);
        chk(mod_ctrl, 32'h07);
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h8);
        chk(mod_ctrl, 32'h07);
        wr(8'h08, 32'hFFFFFE98);
        chk(32'(bpsk_phase), 32'hFFFFFE98);
        wr(8'h08, 32'd361);
        chk(32'(bpsk_phase), 32'hFFFFFE98);
        wr(8'h24, 32'd360);
        chk(32'(start_phase), 32'd360);
    endtask : mod_enables
    task keying;
        logic k;
        int n;
        wr(8'h14, 32'h40);
        for (int i = 0; i < 2; i++) begin
            wr(8'h00, 32'h100 | (32'h10 << i));
            level(1'b1);
            tick(25);
            chk(key_shift, 1'b1);
            level(1'b0);
            tick(25);
            chk(key_shift, 1'b0);
        end
        wr(8'h28, 32'd1000);
        wr(8'h04, 32'h3);
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, 32'h100 | (32'h1 << i));
            @(posedge ref_clk);
            want_analog <= 12'sd2047;
            tick(3);
            chk(32'(mod_term), 32'd999);
            @(posedge ref_clk);
            want_analog <= -12'sd2048;
            tick(3);
            chk(32'(mod_term), 32'hFFFFFC18);
        end
        wr(8'h0C, 32'd4);
        wr(8'h00, 32'h010);
        tick(12);
        k = key_shift;
        for (n = 0; n < 20 && key_shift === k; n++)
            tick(1);
        for (int j = 0; j < 2; j++) begin
            k = key_shift;
            for (n = 0; n < 20 && key_shift === k; n++)
                tick(1);
            chk(n, 4);
        end
    endtask : keying
    task bursts;
        wr(8'h04, 32'h0);
        wr(8'h18, 32'd3);
        wr(8'h18, 32'd0);
        rd(8'h18, rv);
        chk(rv, 32'd3);
        wr(8'h14, 32'h11);
        chk(mod_ctrl.en, 32'h0);
        wait_on(1'b0);
        @(posedge ref_clk);
        manual_trigger <= 1'b1;
        @(posedge ref_clk);
        manual_trigger <= 1'b0;
        wait_on(1'b1);
        for (int i = 0; i < 3; i++) begin
            chk(output_on, 1'b1);
            pulse_end;
        end
        tick(2);
        chk(output_on, 1'b0);
        level(1'b1);
        wait_on(1'b1);
        repeat (3) pulse_end;
        level(1'b0);
        wr(8'h14, 32'h21);
        wr(8'h2C, 32'h1);
        wait_on(1'b1);
        wr(8'h1C, 32'h1);
        wr(8'h14, 32'h01);
        repeat (3) pulse_end;
        wait_on(1'b1);
        repeat (3) pulse_end;
        tick(2);
        chk(output_on, 1'b0);
        wr(8'h14, 32'h03);
        level(1'b1);
        wait_on(1'b1);
        level(1'b0);
        tick(25);
        chk(output_on, 1'b1);
        pulse_end;
        tick(2);
        chk(output_on, 1'b0);
        wr(8'h14, 32'h07);
        wait_on(1'b1);
        chk(output_on, 1'b1);
        wr(8'h04, 32'h4);
        level(1'b1);
        wait_on(1'b0);
        chk(output_on, 1'b0);
        wr(8'h04, 32'h10);
        chk(output_on, 1'b1);
        wr(8'h00, 32'h001);
        chk(sweep_on, 1'b0);
    endtask : bursts

    initial begin
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        tick(1);
        mod_enables;
        keying;
        bursts;
        test_done;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        test_done;
    end
endmodule : modulation_burst_control_tb_top
`default_nettype wire
